// file: src/control_serial_link_decoder.sv
// front-end command decoder: frame hunt, opcode decode, event buffers
`timescale 1ns/1ps
module control_serial_link_decoder (
   input wire logic clock_i,
   input wire logic nrst_i,
   control_serial_link_if.receiver link,
   input wire logic [7:0] fe_data_i,
   output logic cmd_strobe_o,
   output logic [4:0] cmd_op_o,
   output logic [4:0] cmd_addr_o,
   output logic [63:0] cmd_data_o,
   output logic [4:0] div_count_o,
   output logic [15:0] time_count_o,
   output logic buf_empty_o,
   output logic buf_full_o,
   output logic ev_valid_o,
   output logic [4:0] ev_tag_o,
   output logic [15:0] ev_time_o,
   output logic [7:0] ev_data_o,
   output logic [63:0] enable_reg_o,
   output logic [7:0] dac_value_o,
   output logic [4:0] dac_addr_o,
   output logic [4:0] sub_reset_o
);
   localparam int NB = control_serial_link_pkg::NBUF;
   localparam int PTR_W_L = control_serial_link_pkg::PTR_W;
   typedef enum logic [2:0] {
      S_HUNT = 3'b000, S_OP = 3'b001, S_ADDR = 3'b010,
      S_DATA = 3'b011, S_EXEC = 3'b100
   } st_e_t;
   typedef struct packed {
      logic [4:0] tag;
      logic [15:0] tim;
      logic [7:0] dat;
   } ev_t;
   typedef struct packed {
      st_e_t st;
      logic prev;
      logic [6:0] zeros;
      logic [4:0] op;
      logic [4:0] addr;
      logic [6:0] len;
      logic [4:0] div;
      logic [15:0] tcnt;
      logic [PTR_W_L-1:0] wr;
      logic [PTR_W_L-1:0] rd;
      logic [PTR_W_L:0] fill;
      ev_t [NB-1:0] ev;
      logic ev_valid;
      ev_t ev_out;
      logic strobe;
      logic [4:0] c_op;
      logic [4:0] c_addr;
      logic [63:0] c_data;
      logic [63:0] en_reg;
      logic [7:0] dac;
      logic [4:0] dac_addr;
      logic [4:0] sub_rst;
   } st_t;
   st_t s_q;
   st_t s_d;
   logic sh_clear;
   logic sh_shift;
   logic [63:0] sh_word;
   logic [6:0] sh_cnt;
   logic bit_in;
   logic [63:0] field;

   assign bit_in = link.ser; // one bit per clock

   frame_shifter frame_shifter_i (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .clear_i(sh_clear),
      .shift_i(sh_shift),
      .bit_i(bit_in),
      .word_o(sh_word),
      .count_o(sh_cnt)
   );

   always_comb begin
      s_d = s_q;
      sh_clear = 1'b0;
      sh_shift = 1'b0;
      field = '0;
      s_d.prev = bit_in;
      s_d.strobe = 1'b0;
      s_d.ev_valid = 1'b0;
      // free-running divider and timing counter
      s_d.div = s_q.div + 5'h01;
      s_d.tcnt = s_q.tcnt + 16'h0001;
      s_d.zeros = bit_in ? 7'h00 :
                  (s_q.zeros == 7'(control_serial_link_pkg::IDLE_ZEROS) ?
                   s_q.zeros : s_q.zeros + 7'h01);
      unique case (s_q.st)
         S_HUNT: begin
            sh_clear = 1'b1;
            if (bit_in && !s_q.prev) begin
               s_d.st = S_OP;
            end
         end
         S_OP: begin
            sh_shift = 1'b1; // lsb first
            if (sh_cnt == 7'(control_serial_link_pkg::OP_W - 1)) begin
               s_d.op = {bit_in, sh_word[63:60]};
               sh_clear = 1'b1;
               sh_shift = 1'b0;
               if (control_serial_link_pkg::is_runtime({bit_in, sh_word[63:60]})) begin
                  s_d.len = control_serial_link_pkg::LEN_FIVE;
                  s_d.st = S_DATA;
               end else begin
                  // table lookup, undefined ones get zero
                  s_d.len = control_serial_link_pkg::sub_len({bit_in, sh_word[63:60]});
                  s_d.st = S_ADDR;
               end
            end
         end
         S_ADDR: begin
            sh_shift = 1'b1;
            if (sh_cnt == 7'(control_serial_link_pkg::ADDR_W - 1)) begin
               s_d.addr = {bit_in, sh_word[63:60]};
               sh_clear = 1'b1;
               sh_shift = 1'b0;
               s_d.st = (s_q.len == control_serial_link_pkg::LEN_ZERO) ? S_EXEC : S_DATA;
            end
         end
         S_DATA: begin
            sh_shift = 1'b1; // zero data bits never restart hunt
            if (sh_cnt == s_q.len - 7'h01) begin
               s_d.st = S_EXEC;
            end
         end
         S_EXEC: begin
            // decode one clock after last bit, always
            // lsb-first align
            field = sh_word >> (control_serial_link_pkg::LEN_SIXTYFOUR - s_q.len);
            s_d.strobe = 1'b1;
            s_d.c_op = s_q.op;
            s_d.c_addr = s_q.addr;
            s_d.c_data = field;
            unique case (s_q.op)
               control_serial_link_pkg::OP_NULL: ; // no local action
               control_serial_link_pkg::OP_CLEAR: begin
                  // pointers only; contents and setup regs kept
                  s_d.wr = '0;
                  s_d.rd = '0;
                  s_d.fill = '0;
               end
               control_serial_link_pkg::OP_SYNC: begin
                  s_d.div = '0; // events stay
                  s_d.tcnt = '0;
               end
               control_serial_link_pkg::OP_TRIG: begin
                  // full buffers: the trigger is dropped, nothing is stored
                  if (s_q.fill != (PTR_W_L+1)'(NB)) begin
                     s_d.ev[s_q.wr] = '{tag: field[4:0], tim: s_q.tcnt,
                                        dat: fe_data_i};
                     s_d.wr = s_q.wr + PTR_W_L'(1);
                     s_d.fill = s_q.fill + (PTR_W_L+1)'(1);
                  end
               end
               control_serial_link_pkg::OP_READ: begin
                  if (s_q.fill != '0) begin
                     s_d.ev_out = s_q.ev[s_q.rd]; // oldest first
                     s_d.ev_valid = 1'b1;
                     s_d.rd = s_q.rd + PTR_W_L'(1);
                     s_d.fill = s_q.fill - (PTR_W_L+1)'(1);
                  end
               end
               control_serial_link_pkg::OP_SUB_WR64: s_d.en_reg = field;
               control_serial_link_pkg::OP_SUB_WR8: begin
                  s_d.dac = field[7:0];
                  s_d.dac_addr = s_q.addr;
               end
               control_serial_link_pkg::OP_SUB_RESET: s_d.sub_rst = s_q.addr;
               default: ; // undefined and OP_SUB_RD64: no action
            endcase
            sh_clear = 1'b1;
            s_d.st = S_HUNT;
         end
         default: s_d.st = S_HUNT;
      endcase
      // long zero run forces idle
      // the new count is used, so a start bit after idle is never lost
      if (s_d.zeros == 7'(control_serial_link_pkg::IDLE_ZEROS) && s_q.st != S_EXEC) begin
         s_d.st = S_HUNT;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cmd_strobe_o = s_q.strobe;
   assign cmd_op_o = s_q.c_op;
   assign cmd_addr_o = s_q.c_addr;
   assign cmd_data_o = s_q.c_data;
   assign div_count_o = s_q.div;
   assign time_count_o = s_q.tcnt;
   assign buf_empty_o = (s_q.fill == '0);
   assign buf_full_o = (s_q.fill == (PTR_W_L+1)'(NB));
   assign ev_valid_o = s_q.ev_valid;
   assign ev_tag_o = s_q.ev_out.tag;
   assign ev_time_o = s_q.ev_out.tim;
   assign ev_data_o = s_q.ev_out.dat;
   assign enable_reg_o = s_q.en_reg;
   assign dac_value_o = s_q.dac;
   assign dac_addr_o = s_q.dac_addr;
   assign sub_reset_o = s_q.sub_rst;
endmodule

// file: include/control_serial_link_pkg.sv
// shared constants and helper functions for the serial command link
package control_serial_link_pkg;
   localparam int OP_W = 5;
   localparam int RT_DATA_W = 5;
   localparam int ADDR_W = 5;
   localparam int SUB_DATA_MAX = 64;
   localparam int CNT_W = 7;
   // idle zeros that force the decoder idle; longer than any zero run
   // a legal frame can hold, so a long all-zero data field is never cut
   localparam int IDLE_ZEROS = 80;
   localparam logic [4:0] OP_NULL = 5'h00;
   localparam logic [4:0] OP_CLEAR = 5'h01;
   localparam logic [4:0] OP_SYNC = 5'h02;
   localparam logic [4:0] OP_TRIG = 5'h03;
   localparam logic [4:0] OP_READ = 5'h04;
   localparam logic [4:0] OP_RT_LAST = 5'h0b;
   localparam logic [4:0] OP_SUB_FIRST = 5'h0c;
   localparam logic [4:0] OP_SUB_LAST = 5'h1e;
   localparam logic [6:0] LEN_ZERO = 7'h00;
   localparam logic [6:0] LEN_FIVE = 7'h05;
   localparam logic [6:0] LEN_EIGHT = 7'h08;
   localparam logic [6:0] LEN_SIXTYFOUR = 7'h40;
   localparam logic [4:0] OP_SUB_WR64 = 5'h1d;
   localparam logic [4:0] OP_SUB_WR8 = 5'h1c;
   localparam logic [4:0] OP_SUB_RD64 = 5'h1b;
   localparam logic [4:0] OP_SUB_RESET = 5'h1e;
   localparam int NBUF = 4;
   localparam int PTR_W = 2;
   localparam int TCNT_W = 16;

   // data-field length of each defined subsystem opcode
   function automatic logic [6:0] sub_len(input logic [4:0] op);
      case (op)
         OP_SUB_WR64: sub_len = LEN_SIXTYFOUR;
         OP_SUB_WR8: sub_len = LEN_EIGHT;
         default: sub_len = LEN_ZERO;
      endcase
   endfunction

   function automatic logic is_runtime(input logic [4:0] op);
      is_runtime = (op <= OP_RT_LAST);
   endfunction
endpackage

// file: include/control_serial_link_if.sv
// serial control link joining sender and front-end decoder
`timescale 1ns/1ps
interface control_serial_link_if;
   logic ser;
   modport sender (output ser);
   modport receiver (input ser);
endinterface

// file: src/frame_shifter.sv
// lsb-first serial shift register with bit counter
`timescale 1ns/1ps
module frame_shifter (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic clear_i,
   input wire logic shift_i,
   input wire logic bit_i,
   output logic [63:0] word_o,
   output logic [6:0] count_o
);
   typedef struct packed {
      logic [63:0] word;
      logic [6:0] count;
   } st_t;
   st_t s_q;
   st_t s_d;

   always_comb begin
      s_d = s_q;
      if (clear_i) begin
         s_d.word = '0;
         s_d.count = control_serial_link_pkg::LEN_ZERO;
      end else if (shift_i) begin
         // lsb arrives first, so new bits enter at the top
         s_d.word = {bit_i, s_q.word[63:1]};
         s_d.count = s_q.count + 7'h01;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign word_o = s_q.word;
   assign count_o = s_q.count;
endmodule

// file: src/control_serial_link_sender.sv
// link sender: frames opcode, address/data lsb first with idle zeros
`timescale 1ns/1ps
module control_serial_link_sender (
   input wire logic clock_i,
   input wire logic nrst_i,
   control_serial_link_if.sender link,
   input wire logic req_i,
   input wire logic [4:0] op_i,
   input wire logic [4:0] addr_i,
   input wire logic [63:0] data_i,
   input wire logic [6:0] len_i,
   input wire logic run_mode_i,
   output logic ready_o,
   output logic refused_o
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_START = 3'b001, S_OP = 3'b010,
      S_ADDR = 3'b011, S_DATA = 3'b100
   } st_e_t;
   typedef struct packed {
      st_e_t st;
      logic [4:0] op;
      logic [4:0] addr;
      logic [63:0] data;
      logic [6:0] len;
      logic [6:0] cnt;
      logic ser;
      logic refused;
   } st_t;
   st_t s_q;
   st_t s_d;
   logic rt;

   always_comb begin
      s_d = s_q;
      s_d.refused = 1'b0;
      // op rotates while it is sent; one more turn makes it whole again
      rt = control_serial_link_pkg::is_runtime({s_q.op[0], s_q.op[4:1]});
      unique case (s_q.st)
         S_IDLE: begin
            s_d.ser = 1'b0; // idle link sends zeros
            if (req_i) begin
               // no setup commands during data taking
               if (run_mode_i && !control_serial_link_pkg::is_runtime(op_i)) begin
                  s_d.refused = 1'b1;
               end else begin
                  s_d.op = op_i;
                  s_d.addr = addr_i;
                  s_d.data = data_i;
                  s_d.len = control_serial_link_pkg::is_runtime(op_i) ?
                            control_serial_link_pkg::LEN_FIVE : len_i;
                  // one zero already precedes: we sat idle
                  s_d.st = S_START;
               end
            end
         end
         S_START: begin
            s_d.ser = 1'b1; // start bit
            s_d.cnt = '0;
            s_d.st = S_OP;
         end
         S_OP: begin
            s_d.ser = s_q.op[0]; // lsb first
            s_d.op = {s_q.op[0], s_q.op[4:1]};
            s_d.cnt = s_q.cnt + 7'h01;
            if (s_q.cnt == 7'(control_serial_link_pkg::OP_W - 1)) begin
               s_d.cnt = '0;
               s_d.st = rt ? S_DATA : S_ADDR;
               if (!rt && s_q.len == control_serial_link_pkg::LEN_ZERO) begin
                  s_d.st = S_ADDR;
               end
            end
         end
         S_ADDR: begin
            s_d.ser = s_q.addr[0];
            s_d.addr = {1'b0, s_q.addr[4:1]};
            s_d.cnt = s_q.cnt + 7'h01;
            if (s_q.cnt == 7'(control_serial_link_pkg::ADDR_W - 1)) begin
               s_d.cnt = '0;
               s_d.st = (s_q.len == control_serial_link_pkg::LEN_ZERO) ? S_IDLE : S_DATA;
            end
         end
         S_DATA: begin
            s_d.ser = s_q.data[0]; // data lsb first
            s_d.data = {1'b0, s_q.data[63:1]};
            s_d.cnt = s_q.cnt + 7'h01;
            if (s_q.cnt == s_q.len - 7'h01) begin
               s_d.st = S_IDLE;
            end
         end
         default: s_d.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.ser = s_q.ser;
   assign ready_o = (s_q.st == S_IDLE);
   assign refused_o = s_q.refused;
endmodule

// file: sim/serial_command_decoder_props.sv
// checker on the command link and the decoder outputs
`timescale 1ns/1ps
module serial_command_decoder_props (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic ser,
   input wire logic cmd_strobe_o,
   input wire logic [4:0] cmd_op_o,
   input wire logic buf_empty_o,
   input wire logic buf_full_o,
   input wire logic ev_valid_o,
   input wire logic [15:0] time_count_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);
   sequence s_cmd(logic [4:0] c);
      cmd_strobe_o && cmd_op_o == c;
   endsequence
   // zeros seen in a row; no legal frame holds this many before its strobe
   logic [6:0] quiet_q;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         quiet_q <= '0;
      end else if (ser) begin
         quiet_q <= '0;
      end else if (quiet_q != 7'(control_serial_link_pkg::IDLE_ZEROS)) begin
         quiet_q <= quiet_q + 7'h01;
      end
   end
   sequence s_quiet;
      quiet_q == 7'(control_serial_link_pkg::IDLE_ZEROS);
   endsequence
   property p_gap;
      cmd_strobe_o |=> !cmd_strobe_o [*8];
   endproperty
   a_gap: assert property (p_gap)
      else $error("strobe too soon");
   property p_hunt;
      s_quiet |-> !cmd_strobe_o;
   endproperty
   a_hunt: assert property (p_hunt)
      else $error("strobe without frame");
   property p_excl;
      !(buf_empty_o && buf_full_o);
   endproperty
   a_excl: assert property (p_excl)
      else $error("empty and full");
   property p_clear;
      s_cmd(control_serial_link_pkg::OP_CLEAR) |-> ##[0:2] buf_empty_o && !buf_full_o;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear left buffers");
   property p_sync;
      s_cmd(control_serial_link_pkg::OP_SYNC) |-> ##[0:2] time_count_o < 16'h0004;
   endproperty
   a_sync: assert property (p_sync)
      else $error("sync kept count");
   property p_null;
      s_cmd(control_serial_link_pkg::OP_NULL) |=> $stable(buf_empty_o) [*3];
   endproperty
   a_null: assert property (p_null)
      else $error("null acted");
   property p_read;
      ev_valid_o |-> cmd_op_o == control_serial_link_pkg::OP_READ;
   endproperty
   a_read: assert property (p_read)
      else $error("event without read");
   property p_trig;
      s_cmd(control_serial_link_pkg::OP_TRIG) ##0 buf_empty_o |-> ##[0:2] !buf_empty_o;
   endproperty
   a_trig: assert property (p_trig)
      else $error("trigger not stored");
endmodule

// file: sim/serial_command_decoder_tb.sv
// bench: sender and decoder face each other, plus a hand-driven link
`timescale 1ns/1ps
module serial_command_decoder_tb;
   logic clock_i = 0, nrst_i = 0, req_i = 0, run_mode_i = 0;
   logic [4:0] op_i = 0, addr_i = 0;
   logic [63:0] data_i = 0, r;
   logic [6:0] len_i = 0;
   logic [7:0] fe_data_i = 0;
   logic ready_o, refused_o, cmd_strobe_o, buf_empty_o, buf_full_o;
   logic ev_valid_o, strobe2, empty2;
   logic [4:0] cmd_op_o, cmd_addr_o, ev_tag_o, sub_reset_o, op2;
   logic [4:0] div_count_o, dac_addr_o;
   logic [7:0] ev_data_o, dac_value_o;
   logic [28:0] evq[$], tq[$];
   logic [63:0] cmd_data_o, enable_reg_o, data2;
   logic [15:0] time_count_o, ev_time_o;
   int num_errors = 0, check_count = 0, lat = -1, n2 = 0, t;
   control_serial_link_if lnk();
   control_serial_link_if lnk2();
   control_serial_link_sender control_serial_link_sender_i (.clock_i, .nrst_i, .link(lnk), .req_i,
      .op_i, .addr_i, .data_i, .len_i, .run_mode_i, .ready_o, .refused_o);
   control_serial_link_decoder control_serial_link_decoder_i (.clock_i, .nrst_i, .link(lnk),
      .fe_data_i, .cmd_strobe_o, .cmd_op_o, .cmd_addr_o, .cmd_data_o,
      .div_count_o, .time_count_o, .buf_empty_o, .buf_full_o,
      .ev_valid_o, .ev_tag_o, .ev_time_o, .ev_data_o, .enable_reg_o,
      .dac_value_o, .dac_addr_o, .sub_reset_o);
   // second decoder fed by hand, so sender faults can be staged
   control_serial_link_decoder control_serial_link_decoder_2_i (.clock_i, .nrst_i, .link(lnk2),
      .fe_data_i, .cmd_strobe_o(strobe2), .cmd_op_o(op2), .cmd_addr_o(),
      .cmd_data_o(data2), .div_count_o(), .time_count_o(),
      .buf_empty_o(empty2), .buf_full_o(), .ev_valid_o(), .ev_tag_o(),
      .ev_time_o(), .ev_data_o(), .enable_reg_o(), .dac_value_o(),
      .dac_addr_o(), .sub_reset_o());
   serial_command_decoder_props props_i (.clock_i, .nrst_i,
      .ser(lnk.ser), .cmd_strobe_o, .cmd_op_o, .buf_empty_o, .buf_full_o,
      .ev_valid_o, .time_count_o);
   initial begin
      forever #25 clock_i = ~clock_i;
   end
   // falling edge: pulses are settled, never raced against their launch
   always @(negedge clock_i) begin
      if (ev_valid_o === 1'b1) evq.push_back({ev_time_o, ev_data_o, ev_tag_o});
      if (strobe2 === 1'b1) n2++;
   end
   task automatic chk(input logic [79:0] got, exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   function automatic int exp_len(input logic [4:0] o);
      if (o <= control_serial_link_pkg::OP_RT_LAST) return 5;
      if (o == control_serial_link_pkg::OP_SUB_WR64) return 64;
      return (o == control_serial_link_pkg::OP_SUB_WR8) ? 8 : 0;
   endfunction
   // one frame through the sender; the wire and the decode are compared
   task automatic send(input logic [4:0] o, a, input logic [63:0] d);
      int n, k, w, nb;
      logic sub;
      logic [79:0] fr, ex, m;
      logic [63:0] dm;
      n = exp_len(o);
      sub = o > control_serial_link_pkg::OP_RT_LAST;
      nb = sub ? 10 + n : 10;
      m = (80'h1 << nb) - 1;
      dm = n == 64 ? '1 : (64'h1 << n) - 1;
      ex = sub ? {6'h0, d, a, o} : {11'h0, d, o};
      op_i = o;
      addr_i = a;
      data_i = d;
      len_i = 7'(n);
      req_i = 1;
      for (w = 0; w < 40 && ready_o !== 1'b1; w++) @(posedge clock_i) #1;
      @(posedge clock_i) #1;
      req_i = 0;
      chk(lnk.ser, 0);
      for (w = 0; w < 4 && lnk.ser !== 1'b1; w++) @(posedge clock_i) #1;
      fr = 0;
      for (k = 0; k < nb; k++) begin
         @(posedge clock_i) #1;
         fr[k] = lnk.ser;
      end
      chk(fr & m, ex & m);
      for (w = 0; w < 12 && cmd_strobe_o !== 1'b1; w++) @(posedge clock_i) #1;
      if (lat < 0) lat = w;
      chk(w, lat);
      chk(cmd_op_o, o);
      if (o == control_serial_link_pkg::OP_SYNC) chk({div_count_o, time_count_o}, 0);
      if (n > 0) chk(cmd_data_o, d & dm);
      if (sub) chk(cmd_addr_o, a);
   endtask
   task automatic bits(input logic [63:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         lnk2.ser = v[i];
         @(posedge clock_i) #1;
      end
   endtask
   initial begin
      lnk2.ser = 0;
      r = 64'($urandom(32'h3ba9));
      repeat (5) @(posedge clock_i);
      #1 nrst_i = 1;
      chk(buf_empty_o, 1);
      chk(buf_full_o, 0);
      for (t = 0; t < 12; t++) send(5'(t), 0, 64'($urandom));
      send(control_serial_link_pkg::OP_TRIG, 0, 64'h1f);
      send(control_serial_link_pkg::OP_CLEAR, 0, 0);
      chk(buf_empty_o, 1);
      evq.delete();
      for (t = 0; t < 5; t++) begin
         r = 64'($urandom);
         fe_data_i = r[15:8];
         send(control_serial_link_pkg::OP_TRIG, 0, r);
         // the counter moved on at the very edge that stored it
         if (t < 4) begin
            tq.push_back({16'(time_count_o - 16'h0001), r[15:8], r[4:0]});
         end
      end
      chk(buf_full_o, 1);
      send(control_serial_link_pkg::OP_SYNC, 0, 0);
      for (t = 0; t < 5; t++) send(control_serial_link_pkg::OP_READ, 0, 0);
      repeat (4) @(posedge clock_i) #1;
      chk(evq.size(), 4);
      for (t = 0; t < 4; t++) chk(evq[t], tq[t]);
      chk(buf_empty_o, 1);
      r = {32'($urandom), 32'($urandom)};
      send(control_serial_link_pkg::OP_SUB_WR64, 0, r);
      chk(enable_reg_o, r);
      send(control_serial_link_pkg::OP_SUB_WR8, 5'h1f, 64'h5a);
      chk({dac_addr_o, dac_value_o}, 13'h1f5a);
      send(control_serial_link_pkg::OP_SUB_RD64, 5'h3, 0);
      send(control_serial_link_pkg::OP_SUB_RESET, 5'h13, 0);
      chk(sub_reset_o, 5'h13);
      send(5'h0c, 5'h7, 64'h3);
      send(5'h1f, 5'h1, 0);
      send(control_serial_link_pkg::OP_CLEAR, 0, 0);
      chk(enable_reg_o, r);
      run_mode_i = 1;
      op_i = control_serial_link_pkg::OP_SUB_WR64;
      req_i = 1;
      @(posedge clock_i) #1;
      req_i = 0;
      t = 0;
      repeat (6) begin
         if (refused_o === 1'b1) t++;
         chk(lnk.ser, 0);
         @(posedge clock_i) #1;
      end
      chk(t, 1);
      run_mode_i = 0;
      bits(64'h2, 18);
      chk(n2, 1);
      chk(empty2, 1);
      bits(64'($urandom), 10);
      // enough zeros to finish any stray frame and to force idle
      bits(0, 48);
      bits(0, 48);
      r = 64'($urandom);
      bits({r[4:0], control_serial_link_pkg::OP_TRIG, 2'b10}, 18);
      chk(op2, control_serial_link_pkg::OP_TRIG);
      chk(data2, 64'(r[4:0]));
      chk(empty2, 0);
      end_sim;
   end
   // the run needs under a thousand cycles; this cuts a hang short
   initial begin
      #(50 * 20000);
      num_errors++;
      end_sim;
   end
endmodule
